// >>> logic/acf_flags.sv
// Chosen here: the APB slave port and the address map.
`timescale 1ns/100ps
// Behaviour
// [RL1] bus writes never touch timeout/power-down flags
// [RL2] timeout: cleared by power-up, clear, halt; set by timeout
// [RL3] power-down: cleared by power-up, clear; set by halt
// [RL4] sign-xor equals overflow xor result msb
// [RL5] subtract group copies zero into chained zero
// [RL6] borrow-subtract group ANDs chained zero with zero
// [RL7] other instructions keep chained zero
// [RL8] carry: add carry-out, subtract no-borrow
// [RL9] rotate through carry swaps carry and shifted bit
// [RL10] aux carry from low nibble, same sense
// [RL11] zero set exactly when result is zero
// [RL12] overflow: carry into msb differs from carry out
// [RL13] flags never saved automatically on call/interrupt
// [RL14] 8-bit layout, upper four read-only, lower writable
// [RL15] timeout and power-down read zero after power-on
// [RL16] flags change only when affecting operation completes
module acf_flags #(
  parameter int ADDR_W = 12
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  input wire logic I_CE,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_OP_VALID,
  input wire logic [3:0] I_OP_CODE,
  input wire logic [7:0] I_OP_A,
  input wire logic [7:0] I_OP_B,
  output logic [7:0] O_OP_RESULT,
  output logic [7:0] O_FLAGS,
  input wire logic I_WDT_TIMEOUT,
  input wire logic I_WATCHDOG_CLEAR_INSTR,
  input wire logic I_HALT_INSTR
);

  // ==========================================================================
  // state
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [7:0] result_reg;
  logic [7:0] result_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;

  // ==========================================================================
  // bus decode
  logic setup_phase;
  logic access_phase;
  logic hit_flags;
  logic hit_result;
  logic bus_write;

  assign setup_phase = I_PSEL & ~I_PENABLE;
  assign access_phase = I_PSEL & I_PENABLE;
  assign hit_flags = (I_PADDR == ADDR_W'(acf_pkg::ACF_OFS_FLAGS));
  assign hit_result = (I_PADDR == ADDR_W'(acf_pkg::ACF_OFS_RESULT));
  // a frozen clock enable stretches the access phase so no write is lost
  assign O_PREADY = access_phase & I_CE;
  assign O_PSLVERR = access_phase & ~(hit_flags | hit_result);
  assign bus_write = access_phase & I_CE & I_PWRITE & hit_flags;

  // ==========================================================================
  // arithmetic core
  acf_pkg::acf_op_t op;
  logic is_add;
  logic is_sub;
  logic carry_in;
  logic [7:0] b_eff;
  logic [8:0] sum9;
  logic [4:0] nib5;
  logic [7:0] low8;
  logic [7:0] alu_res;

  always_comb begin
    op = acf_pkg::acf_op_t'(I_OP_CODE);
    is_add = (op == acf_pkg::ACF_OP_ADD) || (op == acf_pkg::ACF_OP_ADC);
    is_sub = (op == acf_pkg::ACF_OP_SUB) || (op == acf_pkg::ACF_OP_SBC);
    // subtraction is a + ~b + carry, so carry reads as "no borrow"
    b_eff = is_sub ? ~I_OP_B : I_OP_B;
    case (op)
      acf_pkg::ACF_OP_ADC: carry_in = flags_reg[acf_pkg::ACF_BIT_C];
      acf_pkg::ACF_OP_SUB: carry_in = 1'b1;
      acf_pkg::ACF_OP_SBC: carry_in = flags_reg[acf_pkg::ACF_BIT_C];
      default: carry_in = 1'b0;
    endcase
    sum9 = {1'b0, I_OP_A} + {1'b0, b_eff} + {8'h00, carry_in};
    nib5 = {1'b0, I_OP_A[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, carry_in};
    low8 = {1'b0, I_OP_A[6:0]} + {1'b0, b_eff[6:0]} + {7'h00, carry_in};
    case (op)
      acf_pkg::ACF_OP_AND: alu_res = I_OP_A & I_OP_B;
      acf_pkg::ACF_OP_OR: alu_res = I_OP_A | I_OP_B;
      acf_pkg::ACF_OP_XOR: alu_res = I_OP_A ^ I_OP_B;
      acf_pkg::ACF_OP_RLC: alu_res = {I_OP_A[6:0], flags_reg[acf_pkg::ACF_BIT_C]}; // RL9
      acf_pkg::ACF_OP_RRC: alu_res = {flags_reg[acf_pkg::ACF_BIT_C], I_OP_A[7:1]}; // RL9
      default: alu_res = sum9[7:0];
    endcase
  end

  // ==========================================================================
  // flag update
  logic arith_op;
  logic logic_op;
  logic zero_res;
  logic ov_new;

  always_comb begin
    flags_next = flags_reg;
    result_next = result_reg;
    arith_op = I_OP_VALID && (is_add || is_sub);
    logic_op = I_OP_VALID && ((op == acf_pkg::ACF_OP_AND) || (op == acf_pkg::ACF_OP_OR) ||
                              (op == acf_pkg::ACF_OP_XOR));
    zero_res = (alu_res == 8'h00);
    ov_new = low8[7] ^ sum9[8];
    // software reaches only the low nibble; an operation in the same cycle wins
    if (bus_write) begin
      flags_next = (flags_reg & ~acf_pkg::ACF_SW_WRITE_MASK) |
                   (I_PWDATA[7:0] & acf_pkg::ACF_SW_WRITE_MASK); // RL1 RL14
    end
    if (I_OP_VALID && (op != acf_pkg::ACF_OP_NOP)) begin
      result_next = alu_res;
    end
    if (arith_op) begin // RL16
      flags_next[acf_pkg::ACF_BIT_C] = sum9[8]; // RL8
      flags_next[acf_pkg::ACF_BIT_AC] = nib5[4]; // RL10
      flags_next[acf_pkg::ACF_BIT_Z] = zero_res; // RL11
      flags_next[acf_pkg::ACF_BIT_OV] = ov_new; // RL12
      flags_next[acf_pkg::ACF_BIT_SC] = ov_new ^ alu_res[7]; // RL4
    end
    if (logic_op) begin
      flags_next[acf_pkg::ACF_BIT_Z] = zero_res; // RL11
    end
    if (I_OP_VALID && ((op == acf_pkg::ACF_OP_RLC) || (op == acf_pkg::ACF_OP_RRC))) begin
      flags_next[acf_pkg::ACF_BIT_C] = (op == acf_pkg::ACF_OP_RLC) ? I_OP_A[7] : I_OP_A[0]; // RL9
    end
    // chained zero: other operations fall through and keep it
    if (I_OP_VALID && (op == acf_pkg::ACF_OP_SUB)) begin // RL7
      flags_next[acf_pkg::ACF_BIT_CZ] = zero_res; // RL5
    end else if (I_OP_VALID && (op == acf_pkg::ACF_OP_SBC)) begin
      flags_next[acf_pkg::ACF_BIT_CZ] = flags_reg[acf_pkg::ACF_BIT_CZ] & zero_res; // RL6
    end
    // watchdog clear clears both; halt clears timeout and sets power-down
    if (I_WATCHDOG_CLEAR_INSTR) begin
      flags_next[acf_pkg::ACF_BIT_TO] = 1'b0; // RL2
      flags_next[acf_pkg::ACF_BIT_PDF] = 1'b0; // RL3
    end
    if (I_HALT_INSTR) begin
      flags_next[acf_pkg::ACF_BIT_TO] = 1'b0; // RL2
      flags_next[acf_pkg::ACF_BIT_PDF] = 1'b1; // RL3
    end
    // a time-out in the clearing cycle is not lost
    if (I_WDT_TIMEOUT) begin
      flags_next[acf_pkg::ACF_BIT_TO] = 1'b1; // RL2
    end
  end

  // ==========================================================================
  // read data, sampled in the setup phase so it comes from a flip-flop
  always_comb begin
    prdata_next = prdata_reg;
    if (setup_phase) begin
      if (I_PADDR == ADDR_W'(acf_pkg::ACF_OFS_FLAGS)) begin
        prdata_next = {24'h00_0000, flags_reg}; // RL14
      end else if (I_PADDR == ADDR_W'(acf_pkg::ACF_OFS_RESULT)) begin
        prdata_next = {24'h00_0000, result_reg};
      end else begin
        prdata_next = acf_pkg::ACF_RDATA_RESET;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      flags_reg <= acf_pkg::ACF_FLAGS_RESET; // RL15
      result_reg <= acf_pkg::ACF_RESULT_RESET;
      prdata_reg <= acf_pkg::ACF_RDATA_RESET;
    end else if (I_CE) begin
      flags_reg <= flags_next;
      result_reg <= result_next;
      prdata_reg <= prdata_next;
    end
  end

  assign O_PRDATA = prdata_reg;
  assign O_OP_RESULT = result_reg;
  // the flags are a plain register: no stack path exists, software saves them
  assign O_FLAGS = flags_reg; // RL13

endmodule // acf_flags

// >>> logic/acf_pkg.sv
package acf_pkg;

  // ==========================================================================
  // register map (byte addresses on the 32-bit bus)
  localparam logic [11:0] ACF_OFS_FLAGS = 12'h000;
  localparam logic [11:0] ACF_OFS_RESULT = 12'h004;

  // ==========================================================================
  // condition flag bit positions
  localparam int ACF_BIT_C = 0;
  localparam int ACF_BIT_AC = 1;
  localparam int ACF_BIT_Z = 2;
  localparam int ACF_BIT_OV = 3;
  localparam int ACF_BIT_PDF = 4;
  localparam int ACF_BIT_TO = 5;
  localparam int ACF_BIT_CZ = 6;
  localparam int ACF_BIT_SC = 7;

  // software may write only the low four bits
  localparam logic [7:0] ACF_SW_WRITE_MASK = 8'h0F;

  // ==========================================================================
  // reset values
  localparam logic [7:0] ACF_FLAGS_RESET = 8'h00;
  localparam logic [7:0] ACF_RESULT_RESET = 8'h00;
  localparam logic [31:0] ACF_RDATA_RESET = 32'h0000_0000;

  // ==========================================================================
  // operation codes presented by the core
  typedef enum logic [3:0] {
    ACF_OP_NOP = 4'b0000,
    ACF_OP_ADD = 4'b0001,
    ACF_OP_ADC = 4'b0010,
    ACF_OP_SUB = 4'b0011,
    ACF_OP_SBC = 4'b0100,
    ACF_OP_AND = 4'b0101,
    ACF_OP_OR = 4'b0110,
    ACF_OP_XOR = 4'b0111,
    ACF_OP_RLC = 4'b1000,
    ACF_OP_RRC = 4'b1001
  } acf_op_t;

endpackage

// >>> tb/acf_flags_chk.sv
`timescale 1ns/100ps
module acf_flags_chk (
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  input wire logic I_CE,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic O_PREADY,
  input wire logic I_OP_VALID,
  input wire logic [3:0] I_OP_CODE,
  input wire logic [7:0] O_OP_RESULT,
  input wire logic [7:0] O_FLAGS,
  input wire logic I_WDT_TIMEOUT,
  input wire logic I_WATCHDOG_CLEAR_INSTR,
  input wire logic I_HALT_INSTR
);
  // ==========================================================================
  // flag relations
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);
  logic v;
  logic ev;
  logic wr;
  assign v = I_CE && I_OP_VALID;
  assign ev = I_WDT_TIMEOUT || I_WATCHDOG_CLEAR_INSTR || I_HALT_INSTR;
  assign wr = I_PSEL && I_PENABLE && I_PWRITE;
  AST_WR_KEEP: assert property (wr && O_PREADY && !ev |=> $stable(O_FLAGS[5:4]))
    else $error("bus write moved timeout or power-down");
  AST_TO_SET: assert property (I_CE && I_WDT_TIMEOUT |=> O_FLAGS[5])
    else $error("timeout flag not set");
  AST_PD_SET: assert property (I_CE && I_HALT_INSTR |=> O_FLAGS[4])
    else $error("power-down flag not set");
  AST_CLR: assert property (I_CE && I_WATCHDOG_CLEAR_INSTR && !I_HALT_INSTR
    && !I_WDT_TIMEOUT |=> O_FLAGS[5:4] == 2'h0) else $error("clear left flags set");
  AST_SC: assert property (v && I_OP_CODE >= 4'h1 && I_OP_CODE <= 4'h4
    |=> O_FLAGS[7] == (O_FLAGS[3] ^ O_OP_RESULT[7])) else $error("sign-xor wrong");
  AST_CZ_SUB: assert property (v && I_OP_CODE == 4'h3 |=> O_FLAGS[6] == O_FLAGS[2])
    else $error("chained zero differs from zero");
  AST_CZ_SBC: assert property (v && I_OP_CODE == 4'h4
    |=> O_FLAGS[6] == ($past(O_FLAGS[6]) & O_FLAGS[2])) else $error("chained zero chain");
  AST_CZ_KEEP: assert property (!(v && (I_OP_CODE == 4'h3 || I_OP_CODE == 4'h4))
    |=> $stable(O_FLAGS[6])) else $error("chained zero changed");
  AST_Z: assert property (v && I_OP_CODE >= 4'h1 && I_OP_CODE <= 4'h7
    |=> O_FLAGS[2] == (O_OP_RESULT == 8'h00)) else $error("zero flag wrong");
  AST_HOLD: assert property (!v && !ev && !wr |=> $stable(O_FLAGS))
    else $error("flags moved without cause");
endmodule // acf_flags_chk

// >>> tb/test_alu_status_flags.sv
`timescale 1ns/100ps
module test_alu_status_flags;
  logic clk = 0, rst_n = 0, ce = 1, psel = 0, pen = 0, pwr = 0, opv = 0, wdt = 0, clr = 0;
  logic halt = 0, pready, pslverr, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] opc = 4'h0;
  logic [7:0] opa = 8'h00, opb = 8'h00, res, flags;
  int mismatches = 0, checks = 0, cyc = 0;
  always #4 clk = ~clk;
  acf_flags DUT (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_OP_VALID(opv), .I_OP_CODE(opc), .I_OP_A(opa),
    .I_OP_B(opb), .O_OP_RESULT(res), .O_FLAGS(flags), .I_WDT_TIMEOUT(wdt),
    .I_WATCHDOG_CLEAR_INSTR(clr), .I_HALT_INSTR(halt));
  // ==========================================================================
  // shared tasks
  task test_done;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // far below the ceiling: the run needs about 75 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      test_done();
    end
  end
  task cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) pen <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    pen <= 0;
    // one idle cycle so the next call never reassigns psel in this time step
    @(posedge clk);
  endtask
  task op(input logic [3:0] c, input logic [7:0] a, b, r, f);
    opv <= 1;
    opc <= c;
    opa <= a;
    opb <= b;
    @(posedge clk) opv <= 0;
    @(posedge clk);
    cmp(res, r);
    cmp(flags, f);
  endtask
  task ev(input logic w, c, h, input logic [7:0] f);
    wdt <= w;
    clr <= c;
    halt <= h;
    @(posedge clk) {wdt, clr, halt} <= 3'h0;
    @(posedge clk);
    cmp(flags, f);
  endtask
  // ==========================================================================
  // scenarios
  task t_arith;
    op(4'h3, 8'h05, 8'h05, 8'h00, 8'h47);
    op(4'h1, 8'h7F, 8'h01, 8'h80, 8'h4A);
    op(4'h1, 8'hFF, 8'h01, 8'h00, 8'h47);
    op(4'h4, 8'h05, 8'h05, 8'h00, 8'h47);
    op(4'h4, 8'h03, 8'h01, 8'h02, 8'h03);
    op(4'h4, 8'h02, 8'h02, 8'h00, 8'h07);
    op(4'h3, 8'h00, 8'h01, 8'hFF, 8'h80);
  endtask
  task t_rot_logic;
    op(4'h8, 8'h81, 8'h00, 8'h02, 8'h81);
    op(4'h9, 8'h02, 8'h00, 8'h81, 8'h80);
    op(4'h5, 8'h0F, 8'hF0, 8'h00, 8'h84);
    op(4'h6, 8'h01, 8'h00, 8'h01, 8'h80);
    op(4'h0, 8'h00, 8'h00, 8'h01, 8'h80);
  endtask
  task t_ce;
    ce <= 0;
    op(4'h1, 8'h00, 8'h00, 8'h01, 8'h80);
    ce <= 1;
  endtask
  task t_bus;
    apb(1, 12'h000, 32'hFFFF_FFFF);
    apb(0, 12'h000, 32'h0);
    cmp(rd, 32'h0000_008F);
    apb(1, 12'h004, 32'h55);
    apb(0, 12'h004, 32'h0);
    cmp(rd, 32'h0000_0001);
    cmp({31'h0000_0000, er}, 32'h0000_0000);
    apb(0, 12'h008, 32'h0);
    cmp(rd, 32'h0000_0000);
    cmp({31'h0000_0000, er}, 32'h0000_0001);
  endtask
  task t_wdt;
    ev(0, 0, 1, 8'h9F);
    ev(1, 0, 0, 8'hBF);
    apb(1, 12'h000, 32'h0);
    apb(0, 12'h000, 32'h0);
    cmp(rd, 32'h0000_00B0);
    ev(0, 1, 0, 8'h80);
  endtask
  task t_reset;
    ev(1, 0, 1, 8'hB0);
    rst_n <= 0;
    repeat (2) @(posedge clk);
    cmp(flags, 32'h0000_0000);
    rst_n <= 1;
    @(posedge clk);
    apb(0, 12'h000, 32'h0);
    cmp(rd, 32'h0000_0000);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    apb(0, 12'h000, 32'h0);
    cmp(rd, 32'h0);
    t_arith();
    t_rot_logic();
    t_ce();
    t_bus();
    t_wdt();
    t_reset();
    test_done();
  end
endmodule // test_alu_status_flags
bind acf_flags acf_flags_chk u_chk (.I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N), .I_CE(I_CE),
  .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .O_PREADY(O_PREADY),
  .I_OP_VALID(I_OP_VALID), .I_OP_CODE(I_OP_CODE), .O_OP_RESULT(O_OP_RESULT), .O_FLAGS(O_FLAGS),
  .I_WDT_TIMEOUT(I_WDT_TIMEOUT), .I_WATCHDOG_CLEAR_INSTR(I_WATCHDOG_CLEAR_INSTR),
  .I_HALT_INSTR(I_HALT_INSTR));
